// ### sram_port_defines.svh
// constants for the synchronous burst sram port
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH
`define ADDR_W 8
`define LANES 4
`define LANE_W 8
`define DEPTH 256
`define BURST_LSB 0
`define BURST_W 2
`define SLEEP_SYNC_STAGES 3
`endif

// ### sram_port_pkg.sv
// types shared by the sram port files
`include "sram_port_defines.svh"
package sram_port_pkg;
	typedef struct packed {
		logic [`ADDR_W-1:0] addr;
		logic procStrobeN;
		logic ctrlStrobeN;
		logic burstStepN;
		logic selAN;
		logic selB;
		logic selCN;
	} addr_bus_type;
	typedef struct packed {
		logic globalWriteN;
		logic byteWriteEnN;
		logic [`LANES-1:0] laneWriteSelN;
	} write_ctl_type;
	typedef struct packed {
		logic [`LANES*`LANE_W-1:0] data;
		logic [`LANES-1:0] parity;
	} word_type;
	typedef enum logic [1:0] {
		DESEL,
		READ,
		WRITE
	} cycle_type;
endpackage

// ### burst_counter.sv
// two-bit wrapping burst counter, linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
module burst_counter (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// control
	input wire logic load,
	input wire logic step,
	input wire logic linearOrder,
	input wire logic [1:0] startIdx,
	// burst low address
	output logic [1:0] burstIdx
);
	logic [1:0] start_q;
	logic [1:0] count_q;
	logic [1:0] count_d;
	logic [1:0] lowBits;
	assign count_d = load ? 2'h0 : (step ? count_q + 2'h1 : count_q);
	// wrap inside the four-location group
	assign lowBits = linearOrder ? start_q + count_q : start_q ^ count_q;
	assign burstIdx = lowBits;
	always_ff @(posedge mclk) begin
		if (srst) begin
			start_q <= 2'h0;
			count_q <= 2'h0;
		end else begin
			if (load) begin
				start_q <= startIdx;
			end
			count_q <= count_d;
		end
	end
endmodule
`default_nettype wire

// ### sync_burst_sram_port.sv
// synchronous burst sram control and data port
//
// What this block does
// - burst step advances internal burst address
// - processor strobe low captures address
// - controller strobe low captures address
// - capture loads two low bits into counter
// - both strobes low: processor strobe wins
// - processor strobe loads nothing when chip_sel_a high, yet still blocks controller strobe
// - byte write only with byte_write_en low
// - sleep request idles device, contents kept
// - input data registered on rising edge
// - read returns data of previously sampled address
// - output enable low drives data and parity
// - tristate during write data and deselect
// - first clock after deselect stays tristate
// - parity like data, written per lane
// - two-bit counter fed by low address
// - global write writes every lane
// - selects sampled only on address load
// - strap low linear, high interleaved
`include "sram_port_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_port (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// address and control
	input wire sram_port_pkg::addr_bus_type addrIn,
	input wire sram_port_pkg::write_ctl_type writeIn,
	input wire logic burstOrderStrap,
	input wire logic sleepReq,
	input wire logic outputEnN,
	// data and parity lanes
	input wire sram_port_pkg::word_type dataIn,
	output sram_port_pkg::word_type dataOut,
	output logic [`LANES-1:0] dataOutEn,
	// status
	output logic asleep
);
	import sram_port_pkg::*;

	localparam int WORD_W = `LANES*`LANE_W + `LANES;

	logic [WORD_W-1:0] mem [0:`DEPTH-1];

	// asynchronous pins through three flops
	logic [`SLEEP_SYNC_STAGES-1:0] sleepSync_q;
	logic [`SLEEP_SYNC_STAGES-1:0] oeSync_q;
	logic sleep_q;
	logic oeN_q;

	// registered inputs
	addr_bus_type addrReg_q;
	write_ctl_type wrReg_q;
	word_type dataReg_q;
	logic strapLinear_q;

	// state
	logic [`ADDR_W-1:0] baseAddr_q;
	logic selected_q;
	logic wasDesel_q;
	cycle_type cycle_q;
	cycle_type cycle_d;
	logic firstAfterDesel_q;
	word_type readData_q;
	logic drive_q;
	logic [`LANES-1:0] laneWrite;

	// decode
	wire procLoad;
	wire ctrlLoad;
	wire anyLoad;
	wire selNow;
	wire stepReq;
	wire writeReq;
	wire globalWrite;
	wire [1:0] burstIdx;
	wire [`ADDR_W-1:0] curAddr;
	wire [`ADDR_W-1:0] accessAddr;
	wire writeNow;
	wire [WORD_W-1:0] writeWord;
	wire [WORD_W-1:0] oldWord;
	wire [WORD_W-1:0] mergedWord;
	wire driveNext;

	assign selNow = !addrReg_q.selAN && addrReg_q.selB && !addrReg_q.selCN;
	assign procLoad = !addrReg_q.procStrobeN && !addrReg_q.selAN;
	assign ctrlLoad = !addrReg_q.ctrlStrobeN && addrReg_q.procStrobeN;
	assign anyLoad = (procLoad || ctrlLoad) && !sleep_q;
	assign stepReq = !addrReg_q.burstStepN && !anyLoad && selected_q && !sleep_q;
	assign globalWrite = !wrReg_q.globalWriteN;
	assign writeReq = globalWrite || (!wrReg_q.byteWriteEnN && !(&wrReg_q.laneWriteSelN));
	assign curAddr = {baseAddr_q[`ADDR_W-1:`BURST_W], burstIdx};
	assign writeWord = {dataReg_q.data, dataReg_q.parity};
	// a controller-strobe write goes to the freshly presented address
	assign accessAddr = anyLoad ? addrReg_q.addr : curAddr;
	assign oldWord = mem[accessAddr];

	// per-lane write merge, parity bit per lane too
	genvar g;
	generate
		for (g = 0; g < `LANES; g = g + 1) begin : laneGen
			assign laneWrite[g] = globalWrite || (!wrReg_q.byteWriteEnN && !wrReg_q.laneWriteSelN[g]);
			assign mergedWord[`LANES+g*`LANE_W +: `LANE_W] = laneWrite[g] ?
				writeWord[`LANES+g*`LANE_W +: `LANE_W] : oldWord[`LANES+g*`LANE_W +: `LANE_W];
			assign mergedWord[g] = laneWrite[g] ? writeWord[g] : oldWord[g];
		end
	endgenerate

	always_comb begin
		cycle_d = cycle_q;
		if (sleep_q) begin
			cycle_d = DESEL;
		end else if (procLoad) begin
			// write inputs ignored on processor-strobe cycle
			cycle_d = selNow ? READ : DESEL;
		end else if (ctrlLoad) begin
			cycle_d = !selNow ? DESEL : (writeReq ? WRITE : READ);
		end else if (selected_q) begin
			cycle_d = writeReq ? WRITE : READ;
		end
	end

	// write lands while the registered write controls and data still stand
	assign writeNow = (cycle_d == WRITE) && !sleep_q;

	// read output enable, masked for write, deselect, first clock out of deselect
	assign driveNext = (cycle_d == READ) && !(wasDesel_q && anyLoad) && !sleep_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			sleepSync_q <= '0;
			oeSync_q <= '1;
			sleep_q <= 1'b0;
			oeN_q <= 1'b1;
		end else begin
			sleepSync_q <= {sleepSync_q[`SLEEP_SYNC_STAGES-2:0], sleepReq};
			oeSync_q <= {oeSync_q[`SLEEP_SYNC_STAGES-2:0], outputEnN};
			if (sleepSync_q[1] == sleepSync_q[2]) begin
				sleep_q <= sleepSync_q[2];
			end
			if (oeSync_q[1] == oeSync_q[2]) begin
				oeN_q <= oeSync_q[2];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			addrReg_q <= '1;
			wrReg_q <= '1;
			dataReg_q <= '0;
			strapLinear_q <= 1'b0;
		end else begin
			addrReg_q <= addrIn;
			wrReg_q <= writeIn;
			dataReg_q <= dataIn;
			strapLinear_q <= !burstOrderStrap;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			baseAddr_q <= '0;
			selected_q <= 1'b0;
			wasDesel_q <= 1'b1;
			cycle_q <= DESEL;
		end else begin
			if (anyLoad) begin
				baseAddr_q <= addrReg_q.addr;
				selected_q <= selNow;
			end
			if (sleep_q) begin
				selected_q <= 1'b0;
			end
			wasDesel_q <= !selected_q || sleep_q;
			cycle_q <= cycle_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (writeNow) begin
			mem[accessAddr] <= mergedWord;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			readData_q <= '0;
			drive_q <= 1'b0;
			firstAfterDesel_q <= 1'b0;
			dataOut <= '0;
			dataOutEn <= '0;
			asleep <= 1'b0;
		end else begin
			readData_q <= {oldWord[WORD_W-1:`LANES], oldWord[`LANES-1:0]};
			drive_q <= driveNext;
			firstAfterDesel_q <= wasDesel_q && anyLoad;
			dataOut <= readData_q;
			dataOutEn <= {`LANES{drive_q && !oeN_q && (cycle_q == READ) && !firstAfterDesel_q}};
			asleep <= sleep_q;
		end
	end

	burst_counter counter (
		.mclk(mclk),
		.srst(srst),
		.load(anyLoad),
		.step(stepReq),
		.linearOrder(strapLinear_q),
		.startIdx(addrReg_q.addr[`BURST_LSB +: `BURST_W]),
		.burstIdx(burstIdx)
	);
endmodule
`default_nettype wire

// ### sram_port_properties.sv
// assertions on the sram port pins
`include "sram_port_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sram_port_properties (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// inputs
	input wire sram_port_pkg::addr_bus_type addrIn,
	input wire sram_port_pkg::write_ctl_type writeIn,
	input wire logic burstOrderStrap,
	input wire logic sleepReq,
	input wire logic outputEnN,
	input wire sram_port_pkg::word_type dataIn,
	// outputs
	input wire sram_port_pkg::word_type dataOut,
	input wire logic [`LANES-1:0] dataOutEn,
	input wire logic asleep
);
	import sram_port_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	oe_off_quiet_a:
		assert property (outputEnN [*6] |-> dataOutEn == '0) else $error("driving with output enable off");
	drive_needs_oe_a:
		assert property ($rose(dataOutEn[0]) |-> !($past(outputEnN) && $past(outputEnN, 2) && $past(outputEnN, 3)
			&& $past(outputEnN, 4))) else $error("drive began without output enable");
	lanes_agree_a:
		assert property (dataOutEn == '0 || dataOutEn == '1) else $error("lane enables differ");
	write_tristate_a:
		assert property (!writeIn.globalWriteN |-> ##2 dataOutEn == '0) else $error("driving during write");
	desel_tristate_a:
		assert property ((!addrIn.ctrlStrobeN && !addrIn.selB) [*6] |-> dataOutEn == '0) else $error("driving deselected");
	sleep_enter_a:
		assert property (sleepReq [*6] |-> asleep) else $error("sleep not entered");
	awake_normal_a:
		assert property (!sleepReq [*6] |-> !asleep) else $error("asleep without request");
	sleep_cause_a:
		assert property ($rose(asleep) |-> $past(sleepReq, 2) || $past(sleepReq, 3) || $past(sleepReq, 4))
			else $error("sleep without request");
endmodule
bind sync_burst_sram_port sram_port_properties sram_port_properties_i(.mclk, .srst, .addrIn, .writeIn,
	.burstOrderStrap, .sleepReq, .outputEnN, .dataIn, .dataOut, .dataOutEn, .asleep);
`default_nettype wire

// ### host_bus_model.sv
// bus master side: sleep line and shared data lines
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	// clock
	input wire logic mclk,
	// commands from the tests
	input wire logic sleepWanted,
	input wire logic hostDrive,
	input wire sram_port_pkg::word_type hostWord,
	// device side
	input wire sram_port_pkg::word_type dataOut,
	input wire logic [3:0] dataOutEn,
	output logic sleepReq,
	output sram_port_pkg::word_type dataIn
);
	import sram_port_pkg::*;
	// sleep held low unless asked
	always_ff @(posedge mclk) begin
		sleepReq <= sleepWanted;
	end
	// undriven lines show the inverse, never a stale value
	assign dataIn = hostDrive ? hostWord : (dataOutEn[0] ? dataOut : ~hostWord);
endmodule
`default_nettype wire

// ### test_sync_burst_sram_port.sv
// self-checking bench for the sram port
`timescale 1ns/1ps
`default_nettype none
module test_sync_burst_sram_port;
	import sram_port_pkg::*;
	logic mclk = 0, srst = 1, oeN = 1, sleepWanted = 0, hostDrive = 0, sleepReq, asleep;
	addr_bus_type addrIn = '{8'h00, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
	write_ctl_type writeIn = '{1'b1, 1'b1, 4'hf};
	word_type hostWord = '0, dataIn, dataOut, w1 = '{32'h11223344, 4'h5}, w2 = '{32'ha5c3e187, 4'ha};
	word_type w3 = '{32'h0f0f0f9e, 4'h3};
	logic [3:0] dataOutEn;
	int bad_count = 0, comparisons = 0;
	always #4 mclk = ~mclk;
	sync_burst_sram_port sync_burst_sram_port_i(.mclk(mclk), .srst(srst), .addrIn(addrIn), .writeIn(writeIn),
		.burstOrderStrap(1'b0), .sleepReq(sleepReq), .outputEnN(oeN), .dataIn(dataIn), .dataOut(dataOut),
		.dataOutEn(dataOutEn), .asleep(asleep));
	host_bus_model host_bus_model_i(.mclk(mclk), .sleepWanted(sleepWanted), .hostDrive(hostDrive),
		.hostWord(hostWord), .dataOut(dataOut), .dataOutEn(dataOutEn), .sleepReq(sleepReq), .dataIn(dataIn));
	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] lanes, input logic byte_write_en_n, input logic gw, input word_type w);
		@(posedge mclk);
		addrIn.addr <= a;
		addrIn.ctrlStrobeN <= 1'b0;
		@(posedge mclk);
		addrIn.ctrlStrobeN <= 1'b1;
		writeIn <= '{gw, byte_write_en_n, lanes};
		hostWord <= w;
		hostDrive <= 1'b1;
		@(posedge mclk);
		writeIn <= '{1'b1, 1'b1, 4'hf};
		hostDrive <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input word_type exp);
		@(posedge mclk);
		addrIn.addr <= a;
		addrIn.ctrlStrobeN <= 1'b0;
		oeN <= 1'b0;
		@(posedge mclk);
		addrIn.ctrlStrobeN <= 1'b1;
		for (int n = 0; n < 8; n++) begin
			@(posedge mclk);
			#1;
			if (dataOutEn === 4'hf) break;
		end
		check(dataOutEn, 36'hf);
		check(dataOut, exp);
		@(posedge mclk);
		oeN <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask
	task automatic complete_run;
		$display("bad_count %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		repeat (4) @(posedge mclk);
		wr(8'h10, 4'h0, 1'b1, 1'b0, w1);
		wr(8'h11, 4'h0, 1'b1, 1'b0, w2);
		rd(8'h10, w1);
		rd(8'h11, w2);
		wr(8'h10, 4'he, 1'b0, 1'b1, w3);
		wr(8'h11, 4'h0, 1'b1, 1'b1, w3);
		rd(8'h10, '{{w1.data[31:8], w3.data[7:0]}, {w1.parity[3:1], w3.parity[0]}});
		rd(8'h11, w2);
		@(posedge mclk);
		addrIn <= '{8'h10, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
		oeN <= 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		check(dataOutEn, 36'h0);
		@(posedge mclk);
		addrIn <= '{8'h10, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		oeN <= 1'b1;
		sleepWanted <= 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		check(asleep, 36'h1);
		@(posedge mclk);
		sleepWanted <= 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		check(asleep, 36'h0);
		rd(8'h11, w2);
		complete_run();
	end
endmodule
`default_nettype wire
